// >>> design/start_sync_pkg.sv
// Package for the start-to-sync pulse logic: timing and reset constants.
// Assumes a single sample clock domain; no software registers.
package start_sync_pkg;

  // Width of the emitted sync pulse in sample clock cycles
  localparam int unsigned SYNC_PULSE_CYCLES = 4;
  // Synchroniser depth for the asynchronous start pin
  localparam int unsigned SYNC_STAGES       = 2;
  // Idle level of start and sync lines (active low)
  localparam logic        LINE_IDLE         = 1'b1;
  // Width of the pulse length counter
  localparam int unsigned PULSE_CNT_W       = 8;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PULSE = 2'b01,
    ST_WAIT  = 2'b10
  } sync_state_t;

endpackage : start_sync_pkg

// >>> design/level_sync.sv
// Two-flop level synchroniser for an asynchronous pin.
// Assumes the destination clock is sys_clk; reset value is the idle level.
`timescale 1ns/10ps
module level_sync #(
  parameter int unsigned STAGES    = start_sync_pkg::SYNC_STAGES,
  parameter logic        RESET_VAL = start_sync_pkg::LINE_IDLE
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      sync_out
);
  import start_sync_pkg::*;

  logic [STAGES-1:0] chain;

  initial begin
    if (STAGES < 2) begin
      $error("level_sync needs at least two stages");
    end
  end

  // First stage feeds only the second; nothing else looks at it
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      chain <= {STAGES{RESET_VAL}};
    end else begin
      chain <= {chain[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain[STAGES-1];

endmodule : level_sync

// >>> design/start_sync_pulse_logic.sv
// Start pin to sync output pulse logic of a multichannel sampling converter.
// Assumes sys_clk is the master sample clock; start pin may be asynchronous.
//
// Notes on behaviour
// [RULE_01] Sync input pulses arrive already aligned to the sample clock.
// [RULE_02] Daisy chains need two successive sync pulses before alignment.
// [RULE_03] Shared clock, one ready flag watched: also two sync pulses.
// [RULE_04] Start pin accepted with no timing relation to sample clock.
// [RULE_05] Each sampled start pulse yields exactly one sync output pulse; the code ignores a start that falls while ST_PULSE is running.
// [RULE_06] Start is resynchronised; sync output changes only on clock.
// [RULE_07] Sync output pulses only when start is used; else idle high.
// [RULE_08] Sync output loops back to own and peers' sync inputs.
// [RULE_09] A system sync pulse on sync input makes start irrelevant.
// [RULE_10] Unused start pin is held high, so no start is seen.
// [RULE_11] Every rising edge of the clock input is a sample clock edge.
// [RULE_12] Start and sync pulses are active low, idle high.
`timescale 1ns/10ps
module start_sync_pulse_logic #(
  parameter int unsigned PULSE_CYCLES = start_sync_pkg::SYNC_PULSE_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic start_b,
  input  wire logic sync_in_b,
  output logic      sync_out_b,
  output logic      sync_seen
);
  import start_sync_pkg::*;

  initial begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << PULSE_CNT_W)) begin
      $error("PULSE_CYCLES out of range for the pulse counter");
    end
  end

  localparam logic [PULSE_CNT_W-1:0] PULSE_LAST =
    PULSE_CNT_W'(PULSE_CYCLES - 1);
  localparam logic [PULSE_CNT_W-1:0] PULSE_LEN  =
    PULSE_CNT_W'(PULSE_CYCLES);

  sync_state_t            state;
  sync_state_t            next_state;
  logic [PULSE_CNT_W-1:0] pulse_cnt;
  logic [PULSE_CNT_W-1:0] next_pulse_cnt;
  logic                   start_sync;
  logic                   start_prev;
  logic                   sync_in_meta;
  logic                   sync_in_s;
  logic                   sync_in_prev;
  logic                   next_sync_out_b;
  logic [PULSE_CNT_W-1:0] low_run;

  // Start pin may come from an unrelated host clock
  level_sync #(
    .STAGES    (SYNC_STAGES),
    .RESET_VAL (LINE_IDLE)
  ) u_start_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in (start_b),
    .sync_out (start_sync)
  ); // see [RULE_04]

  // Sync input is clock aligned by contract, but it is a pin, so two flops
  always_ff @(posedge sys_clk) begin // see [RULE_11]
    if (!rst_b) begin
      sync_in_meta <= LINE_IDLE;
      sync_in_s    <= LINE_IDLE;
      sync_in_prev <= LINE_IDLE;
      start_prev   <= LINE_IDLE;
    end else begin
      sync_in_meta <= sync_in_b;
      sync_in_s    <= sync_in_meta;
      sync_in_prev <= sync_in_s;
      start_prev   <= start_sync;
    end
  end

  // Falling edge of the resynchronised start, active low
  wire start_fall   = start_prev & ~start_sync;            // see [RULE_12]
  wire sync_in_fall = sync_in_prev & ~sync_in_s;           // see [RULE_01]
  wire pulse_done   = (pulse_cnt == PULSE_LAST);

  // At most one pulse per start; a held-high start never leaves idle
  always_comb begin
    next_state     = state;
    next_pulse_cnt = pulse_cnt;
    case (state)
      ST_IDLE: begin
        next_pulse_cnt = '0;
        if (start_fall) begin                              // see [RULE_05]
          next_state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (pulse_done) begin
          next_state = ST_WAIT;
        end else begin
          next_pulse_cnt = pulse_cnt + 1'b1;
        end
      end
      ST_WAIT: begin
        // Start must return high before it can trigger again
        next_pulse_cnt = '0;
        if (start_sync) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state     = ST_IDLE;
        next_pulse_cnt = '0;
      end
    endcase
  end

  // Low only while pulsing; otherwise idle high
  assign next_sync_out_b = (next_state == ST_PULSE) ? ~LINE_IDLE
                                                    : LINE_IDLE; // see [RULE_07]

  // Output taken straight from a flop on the sample clock
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state      <= ST_IDLE;
      pulse_cnt  <= '0;
      sync_out_b <= LINE_IDLE;
    end else begin
      state      <= next_state;
      pulse_cnt  <= next_pulse_cnt;
      sync_out_b <= next_sync_out_b;                       // see [RULE_06]
    end
  end

  // Marks each sync pulse received, whether looped back or system driven
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sync_seen <= 1'b0;
    end else begin
      sync_seen <= sync_in_fall;                           // see [RULE_09]
    end
  end

  // Length of the current low run, so the length check follows PULSE_CYCLES
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      low_run <= '0;
    end else if (!sync_out_b) begin
      low_run <= low_run + 1'b1;
    end else begin
      low_run <= '0;
    end
  end

  // Assertions
  chk_pulse_starts: assert property ( // see [RULE_05]
    @(posedge sys_clk) disable iff (!rst_b)
    (state == ST_IDLE && start_fall) |=> !sync_out_b
  ) else $error("sync pulse did not follow start edge");

  chk_pulse_width: assert property ( // see [RULE_05]
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(sync_out_b) |-> !sync_out_b [*4] ##1 sync_out_b
  ) else $error("sync pulse width wrong");

  chk_no_start_idle: assert property ( // see [RULE_07]
    @(posedge sys_clk) disable iff (!rst_b)
    (state != ST_PULSE && !start_fall) |=> sync_out_b
  ) else $error("sync output low without start");

  chk_one_per_start: assert property ( // see [RULE_05]
    @(posedge sys_clk) disable iff (!rst_b)
    (state == ST_WAIT && !start_sync) |=> (sync_out_b && state == ST_WAIT)
  ) else $error("second sync pulse without start release");

  chk_sync_latency: assert property ( // see [RULE_04]
    @(posedge sys_clk) disable iff (!rst_b)
    ($fell(start_b) && state == ST_IDLE && start_sync)
      |-> ##[3:4] !sync_out_b
  ) else $error("start not resynchronised in time");

  chk_seen_follows: assert property ( // see [RULE_09]
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(sync_in_b) |-> ##3 sync_seen
  ) else $error("sync input pulse not seen");

  chk_held_high: assert property ( // see [RULE_10]
    @(posedge sys_clk) disable iff (!rst_b)
    start_b [*4] |-> ##1 (state != ST_PULSE || pulse_cnt != '0)
  ) else $error("pulse began with start held high");

  chk_state_legal: assert property ( // see [RULE_06]
    @(posedge sys_clk) disable iff (!rst_b)
    (state == ST_IDLE || state == ST_PULSE || state == ST_WAIT)
  ) else $error("illegal state");

  chk_pulse_length: assert property ( // see [RULE_05]
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(sync_out_b) |-> (low_run == PULSE_LEN)
  ) else $error("sync pulse length differs from PULSE_CYCLES");

  chk_reset_idle: assert property ( // see [RULE_12]
    @(posedge sys_clk)
    !rst_b |=> (sync_out_b && !sync_seen)
  ) else $error("outputs not idle after reset");

  chk_seen_single: assert property ( // see [RULE_09]
    @(posedge sys_clk) disable iff (!rst_b)
    sync_seen |=> !sync_seen
  ) else $error("sync seen held longer than one cycle");

  cov_pulse:    cover property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(sync_out_b));
  cov_wait_hi:  cover property (@(posedge sys_clk) disable iff (!rst_b)
    state == ST_WAIT ##1 state == ST_IDLE);
  cov_seen:     cover property (@(posedge sys_clk) disable iff (!rst_b)
    sync_seen);
  cov_refused:  cover property (@(posedge sys_clk) disable iff (!rst_b)
    state == ST_WAIT && !start_sync);
  cov_sys_seen: cover property (@(posedge sys_clk) disable iff (!rst_b)
    sync_seen && sync_out_b);

endmodule : start_sync_pulse_logic

// >>> dv/sync_host_model.sv
// Partner model: host controller and the sync wiring of one converter.
// Assumes the bench drives sys_sync_b off the falling edge of sys_clk.
`timescale 1ns/10ps
module sync_host_model (
  input  wire logic loop_en,
  input  wire logic sys_sync_b,
  input  wire logic sync_out_b,
  output logic      sync_in_b
);
  // Own sync output looped back, or a system pulse in its place
  assign sync_in_b = loop_en ? sync_out_b : sys_sync_b;
endmodule : sync_host_model

// >>> dv/start_sync_pulse_logic_tb.sv
// Bench for the start-to-sync pulse logic, with loopback partner.
// Assumes sync_out_b low 4 cycles from the 3rd edge after start falls.
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module start_sync_pulse_logic_tb;
  logic   sys_clk = 1'b0;
  logic   rst_b = 1'b0;
  logic   start_b = 1'b1;
  logic   loop_en = 1'b1;
  logic   sys_sync_b = 1'b1;
  logic   sync_in_b;
  logic   sync_out_b;
  logic   sync_seen;
  logic   last_out = 1'b1;
  int     npulse = 0;
  int     n0;
  int     miscompares = 0;
  int     total_checks = 0;

  always #4 sys_clk = ~sys_clk;

  start_sync_pulse_logic uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .start_b(start_b), .sync_in_b(sync_in_b), .sync_out_b(sync_out_b),
    .sync_seen(sync_seen));
  sync_host_model host (.loop_en(loop_en), .sys_sync_b(sys_sync_b),
    .sync_out_b(sync_out_b), .sync_in_b(sync_in_b));

  // Counts sync output pulses by their falling edge
  always @(posedge sys_clk) begin
    if (last_out && !sync_out_b) npulse++;
    last_out <= sync_out_b;
  end

  task automatic clk_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : clk_n

  task automatic pulse_start(input int low_cycles);
    @(negedge sys_clk) start_b = 1'b0;
    repeat (low_cycles) @(negedge sys_clk);
    start_b = 1'b1;
  endtask : pulse_start

  task automatic t_start_pulse;
    @(negedge sys_clk) start_b = 1'b0;
    clk_n(2);
    `CHK("out early", 1'b1, sync_out_b)
    clk_n(1);
    `CHK("out low", 1'b0, sync_out_b)
    clk_n(3);
    `CHK("out held", 1'b0, sync_out_b)
    `CHK("seen loop", 1'b1, sync_seen)
    clk_n(1);
    `CHK("out end", 1'b1, sync_out_b)
    `CHK("seen end", 1'b0, sync_seen)
    @(negedge sys_clk) start_b = 1'b1;
    clk_n(8);
  endtask : t_start_pulse

  task automatic t_hold_start;
    n0 = npulse;
    pulse_start(30);
    clk_n(10);
    `CHK("held start", n0 + 1, npulse)
  endtask : t_hold_start

  task automatic t_double;
    n0 = npulse;
    pulse_start(2); // Two successive pulses, as a chain needs
    clk_n(10);
    pulse_start(2);
    clk_n(12);
    `CHK("two starts", n0 + 2, npulse)
  endtask : t_double

  task automatic t_idle;
    n0 = npulse;
    clk_n(40);
    `CHK("idle count", n0, npulse)
    `CHK("idle out", 1'b1, sync_out_b)
  endtask : t_idle

  task automatic t_sys_sync;
    @(negedge sys_clk) loop_en = 1'b0;
    n0 = npulse;
    @(negedge sys_clk) sys_sync_b = 1'b0;
    @(negedge sys_clk) sys_sync_b = 1'b1;
    clk_n(2);
    `CHK("sys seen", 1'b1, sync_seen)
    clk_n(1);
    `CHK("sys seen end", 1'b0, sync_seen)
    clk_n(8);
    `CHK("no out", n0, npulse)
    @(negedge sys_clk) loop_en = 1'b1;
  endtask : t_sys_sync

  // Reset in mid-pulse, then a start right after release
  task automatic t_mid_reset;
    @(negedge sys_clk) start_b = 1'b0;
    clk_n(4);
    `CHK("rst pre pulse", 1'b0, sync_out_b)
    @(negedge sys_clk) rst_b = 1'b0;
    clk_n(1);
    `CHK("rst out", 1'b1, sync_out_b)
    `CHK("rst seen", 1'b0, sync_seen)
    @(negedge sys_clk) start_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    n0 = npulse;
    clk_n(2);
    `CHK("rel out", 1'b1, sync_out_b)
    pulse_start(2);
    clk_n(10);
    `CHK("rst restart", n0 + 1, npulse)
  endtask : t_mid_reset

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    t_start_pulse();
    t_hold_start();
    t_double();
    t_idle();
    t_sys_sync();
    t_mid_reset();
    give_verdict();
  end

  // Whole run needs about 200 cycles; ten times that means a hang
  initial begin
    #16000;
    miscompares++;
    give_verdict();
  end
endmodule : start_sync_pulse_logic_tb
